// ===== rtl/ssx_core.v
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "ssx_defs.vh"

module ssx_core #(
  parameter [15:0] BASE_HALF = `SSX_BASE_HALF
) (
  input  wire        i_sys_clk,          // System clock
  input  wire        i_rst_n,            // Synchronous reset, active low
  input  wire        i_psel,             // APB select
  input  wire        i_penable,          // APB access phase
  input  wire        i_pwrite,           // APB direction
  input  wire [7:0]  i_paddr,            // APB byte address
  input  wire [31:0] i_pwdata,           // APB write data
  output reg  [31:0] o_prdata,           // APB read data
  output wire        o_pready,           // APB ready, no wait states
  output wire        o_pslverr,          // APB error on unmapped address
  input  wire        i_sclk_in,          // Shift clock pin, input side
  output wire        o_sclk_out,         // Shift clock pin, output side
  output wire        o_sclk_oe,          // Shift clock pin drive enable
  input  wire        i_serial_in,        // Serial data in
  output reg         o_serial_out,       // Serial data out
  output reg         o_buffer_event_irq  // Buffer event pulse
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_WAIT  = 2'h1;
  localparam [1:0] ST_SHIFT = 2'h2;

  reg  [1:0] state;
  reg  [7:0] ctrl;
  reg  [7:0] dbuf;
  reg  [7:0] shreg;
  reg  [3:0] bitcnt;
  reg        tx_full;
  reg        rx_full;
  reg        active;
  reg        sclk_int;
  reg        sclk_prev;
  reg        load_tx;
  wire       tick;

  wire       acc;
  wire       wr_ctrl;
  wire       wr_data;
  wire       rd_data;
  wire       mapped;
  wire [1:0] mode;
  wire [2:0] rate;
  wire       ext_clk;
  wire       go;
  wire       abort;
  wire       mode_tx;
  wire       mode_rx;
  wire       fall_ev;
  wire       rise_ev;
  wire       byte_end;
  wire [7:0] sh_next;
  wire       resume_ok;

  //////////////////////////////////////////////////////////////////////////
  // APB decode; every access completes in its first access cycle
  assign acc     = i_psel && i_penable;
  assign wr_ctrl = acc && i_pwrite && (i_paddr == `SSX_ADDR_CTRL);
  assign wr_data = acc && i_pwrite && (i_paddr == `SSX_ADDR_DATA);
  assign rd_data = acc && !i_pwrite && (i_paddr == `SSX_ADDR_DATA);
  assign mapped  = (i_paddr == `SSX_ADDR_CTRL) ||
                   (i_paddr == `SSX_ADDR_DATA) ||
                   (i_paddr == `SSX_ADDR_STATUS);
  assign o_pready  = 1'b1;
  assign o_pslverr = acc && !mapped;

  // Read mux; reserved bits and unmapped words read as zero
  always @* begin
    o_prdata = 32'h00000000;
    case (i_paddr)
      `SSX_ADDR_CTRL: begin
        o_prdata[7:0] = ctrl;
      end
      `SSX_ADDR_DATA: begin
        o_prdata[7:0] = dbuf;
      end
      `SSX_ADDR_STATUS: begin
        o_prdata[`SSX_STAT_ACTIVE] = active;
        o_prdata[`SSX_STAT_SHIFT]  = (state == ST_SHIFT);
      end
      default: begin
        o_prdata = 32'h00000000;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Control register fields
  assign mode    = ctrl[`SSX_CTRL_MODE_HI:`SSX_CTRL_MODE_LO];
  assign rate    = ctrl[`SSX_CTRL_RATE_HI:`SSX_CTRL_RATE_LO];
  assign ext_clk = (rate == `SSX_RATE_EXT);
  assign abort   = ctrl[`SSX_CTRL_ABORT];
  assign go      = ctrl[`SSX_CTRL_START] && !abort &&
                   (mode != `SSX_MODE_RSVD);
  assign mode_tx = (mode == `SSX_MODE_TX) || (mode == `SSX_MODE_TXRX);
  assign mode_rx = (mode == `SSX_MODE_RX) || (mode == `SSX_MODE_TXRX);

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl <= `SSX_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= i_pwdata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Shift clock pin: driven only when the internal clock is chosen
  assign o_sclk_out = sclk_int;
  assign o_sclk_oe  = !ext_clk;

  ssx_clk_div #(
    .BASE_HALF (BASE_HALF)
  ) u_div (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_run     ((state == ST_SHIFT) && !ext_clk),
    .i_rate    (rate),
    .o_tick    (tick)
  );

  // Pin is synchronous to the system clock, so a plain history flop
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sclk_prev <= 1'b1;
    end else begin
      sclk_prev <= i_sclk_in;
    end
  end

  // Shift edges from either source; only honoured while shifting
  assign fall_ev = (state == ST_SHIFT) &&
                   (ext_clk ? (sclk_prev && !i_sclk_in)
                            : (tick && sclk_int));
  assign rise_ev = (state == ST_SHIFT) &&
                   (ext_clk ? (!sclk_prev && i_sclk_in)
                            : (tick && !sclk_int));

  // Incoming bit enters at the top, so the LSB arrives first
  assign sh_next  = {i_serial_in, shreg[7:1]};
  assign byte_end = rise_ev && (bitcnt == (`SSX_BITS - 4'h1));

  // Conditions under which a stopped clock may run again
  assign resume_ok = (mode == `SSX_MODE_TX)   ? tx_full :
                     (mode == `SSX_MODE_RX)   ? !rx_full :
                     (tx_full && !rx_full);

  //////////////////////////////////////////////////////////////////////////
  // Internal shift clock level; rests high whenever not shifting
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sclk_int <= 1'b1;
    end else if (state != ST_SHIFT || abort || ext_clk) begin
      sclk_int <= 1'b1;
    end else if (tick) begin
      sclk_int <= !sclk_int;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Serial output changes only on a falling shift edge, so the last bit
  // of the previous byte stays on the pin until the first low phase
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_serial_out <= 1'b1;
    end else if (fall_ev && mode_tx && !abort) begin
      o_serial_out <= shreg[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Shared data buffer and its two flags
  // A received byte wins over a same-cycle software write; the flag
  // sets are placed after the clears so an event is never lost
  // A write landing with a load keeps the buffer full, since the
  // shifter took the older byte and the new one still waits
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      dbuf    <= 8'h00;
      tx_full <= 1'b0;
      rx_full <= 1'b0;
    end else begin
      if (wr_ctrl &&
          (i_pwdata[`SSX_CTRL_MODE_HI:`SSX_CTRL_MODE_LO] != mode)) begin
        tx_full <= 1'b0;
        rx_full <= 1'b0;
      end
      if (load_tx) begin
        tx_full <= 1'b0;
      end
      if (rd_data) begin
        rx_full <= 1'b0;
      end
      if (wr_data) begin
        dbuf    <= i_pwdata[7:0];
        tx_full <= 1'b1;
      end
      if (byte_end && mode_rx && !abort) begin
        dbuf    <= sh_next;
        rx_full <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // When a transmit byte is taken from the buffer into the shifter
  always @* begin
    load_tx = 1'b0;
    if (!abort && mode_tx && tx_full) begin
      case (state)
        ST_IDLE: begin
          load_tx = go;
        end
        ST_WAIT: begin
          load_tx = go && resume_ok;
        end
        ST_SHIFT: begin
          load_tx = byte_end && go && ext_clk &&
                    (mode == `SSX_MODE_TX);
        end
        default: begin
          load_tx = 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transfer sequencer
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state  <= ST_IDLE;
      shreg  <= 8'h00;
      bitcnt <= 4'h0;
      active <= 1'b0;
    end else if (abort) begin
      // Partial byte is dropped and never reaches the buffer
      state  <= ST_IDLE;
      bitcnt <= 4'h0;
      active <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          bitcnt <= 4'h0;
          if (go) begin
            active <= 1'b1;
            if (mode == `SSX_MODE_RX) begin
              state <= ST_SHIFT;
            end else if (tx_full) begin
              shreg <= dbuf;
              state <= ST_SHIFT;
            end else begin
              state <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          bitcnt <= 4'h0;
          if (!go) begin
            // Start withdrawn while stopped between bytes
            state  <= ST_IDLE;
            active <= 1'b0;
          end else if (resume_ok) begin
            if (mode_tx) begin
              shreg <= dbuf;
            end
            state <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (rise_ev) begin
            shreg  <= sh_next;
            bitcnt <= bitcnt + 4'h1;
          end
          if (byte_end) begin
            bitcnt <= 4'h0;
            if (!go) begin
              state  <= ST_IDLE;
              active <= 1'b0;
            end else if (ext_clk) begin
              // No waits on an outside clock; unless transmit-only mode has a fresh
              // byte ready, the stale shifter content goes out as dummy
              if (load_tx) begin
                shreg <= dbuf;
              end
            end else begin
              state <= ST_WAIT;
            end
          end
        end
        default: begin
          state  <= ST_IDLE;
          active <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Buffer event: transmit byte taken (transmit-only mode) or received byte stored
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_buffer_event_irq <= 1'b0;
    end else begin
      o_buffer_event_irq <= (load_tx && (mode == `SSX_MODE_TX)) ||
                            (byte_end && mode_rx && !abort);
    end
  end

endmodule
`default_nettype wire

// ===== rtl/ssx_defs.vh
`ifndef SSX_DEFS_VH
`define SSX_DEFS_VH

// Register byte offsets on the APB
`define SSX_ADDR_CTRL      8'h00
`define SSX_ADDR_DATA      8'h04
`define SSX_ADDR_STATUS    8'h08

// serial_control_one field positions
`define SSX_CTRL_START     7
`define SSX_CTRL_ABORT     6
`define SSX_CTRL_MODE_HI   5
`define SSX_CTRL_MODE_LO   4
`define SSX_CTRL_RATE_HI   2
`define SSX_CTRL_RATE_LO   0
`define SSX_CTRL_RESET     8'h07

// serial_status_reg field positions
`define SSX_STAT_ACTIVE    3
`define SSX_STAT_SHIFT     2

// transfer_mode_select encodings
`define SSX_MODE_TX        2'h0
`define SSX_MODE_RSVD      2'h1
`define SSX_MODE_TXRX      2'h2
`define SSX_MODE_RX        2'h3

// Clock-rate select code for the external shift clock
`define SSX_RATE_EXT       3'h7

// Internal shift clock: half period in system clocks at rate code 0
`define SSX_BASE_HALF      16'h0004

// Bits per serial byte
`define SSX_BITS           4'h8

`endif

// ===== rtl/ssx_clk_div.v
`timescale 1ns/100ps
`default_nettype none
`include "ssx_defs.vh"

module ssx_clk_div #(
  parameter [15:0] BASE_HALF = `SSX_BASE_HALF
) (
  input  wire       i_sys_clk, // System clock
  input  wire       i_rst_n,   // Synchronous reset, active low
  input  wire       i_run,     // Count only while shifting
  input  wire [2:0] i_rate,    // Rate code, divides by 2^code
  output reg        o_tick     // One pulse per half shift period
);

  wire [15:0] limit;
  reg  [15:0] cnt;

  // Half period doubles with each rate step
  assign limit = (BASE_HALF << i_rate) - 16'h0001;

  //////////////////////////////////////////////////////////////////////////
  // Restart from zero when stopped so each byte starts with a full phase
  always @(posedge i_sys_clk) begin
    if (!i_rst_n || !i_run) begin
      cnt    <= 16'h0000;
      o_tick <= 1'b0;
    end else if (cnt >= limit) begin
      cnt    <= 16'h0000;
      o_tick <= 1'b1;
    end else begin
      cnt    <= cnt + 16'h0001;
      o_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== verif/ssx_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssx_defs.vh"
module ssx_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_sclk_out,
  input wire logic        o_sclk_oe,
  input wire logic        o_serial_out,
  input wire logic        o_buffer_event_irq
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Bus decode from the pins alone
  wire acc = i_psel && i_penable;
  wire hit = i_paddr == `SSX_ADDR_CTRL || i_paddr == `SSX_ADDR_DATA ||
             i_paddr == `SSX_ADDR_STATUS;
  wire wr_ctl = acc && i_pwrite && i_paddr == `SSX_ADDR_CTRL;
  wire rd_st = acc && !i_pwrite && i_paddr == `SSX_ADDR_STATUS;
  //////////////////////////////////////////////////////////////////////
  ready_high_a: assert property (o_pready)
    else $error("pready dropped");
  unmapped_err_a: assert property (o_pslverr == (acc && !hit))
    else $error("pslverr wrong for address");
  upper_zero_a: assert property (acc && !i_pwrite |->
    o_prdata[31:8] == 24'h0) else $error("read data upper bits set");
  // Data moves only with a falling clock, so the last bit is kept before
  out_edge_a: assert property (
    $changed(o_serial_out) && o_sclk_oe |->
    $fell(o_sclk_out)) else $error("data moved off the falling edge");
  // Low phase is at least the rate-0 half period
  low_half_a: assert property (
    $fell(o_sclk_out) && o_sclk_oe |-> (!o_sclk_out)[*4])
    else $error("shift clock low too short");
  irq_pulse_a: assert property (
    o_buffer_event_irq |=> !o_buffer_event_irq)
    else $error("buffer event longer than a cycle");
  abort_park_a: assert property (
    wr_ctl && i_pwdata[`SSX_CTRL_ABORT] |=> ##1 o_sclk_out)
    else $error("clock not parked after abort");
  flag_pair_a: assert property (
    rd_st |-> !(o_prdata[`SSX_STAT_SHIFT] && !o_prdata[`SSX_STAT_ACTIVE]))
    else $error("shift flag without active flag");
  oe_rest_a: assert property ($rose(o_sclk_oe) |-> o_sclk_out)
    else $error("clock driven low when taken over");
  // Main scenarios reached
  c_irq: cover property (o_buffer_event_irq);
  c_err: cover property (o_pslverr);
  c_fall: cover property ($fell(o_sclk_out) && o_sclk_oe);
endmodule
bind ssx_core ssx_chk u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_sclk_out(o_sclk_out), .o_sclk_oe(o_sclk_oe),
  .o_serial_out(o_serial_out), .o_buffer_event_irq(o_buffer_event_irq));
`default_nettype wire

// ===== verif/ssx_peer.sv
`timescale 1ns/100ps
`default_nettype none
module ssx_peer (
  input  wire logic       i_clk,         // System clock
  input  wire logic       i_sck,         // Resolved shift clock line
  input  wire logic       i_so,          // Device serial output
  input  wire logic       i_ld,          // Load a byte to send
  input  wire logic [7:0] i_tx,          // Byte to send
  output logic            o_si = 1'b1,   // Device serial input
  output logic            o_xck = 1'b1,  // External shift clock
  output logic [7:0]      o_rx = 8'h00,  // Byte seen, LSB first
  output logic [3:0]      o_nrx = 4'h0   // Rises since load
);
  logic       sck_q = 1'b1;
  logic [7:0] sh = 8'h00;
  // Drive on the fall, take on the rise; spent bits refill inverted
  always @(posedge i_clk) begin
    sck_q <= i_sck;
    if (i_ld) begin
      sh    <= i_tx;
      o_nrx <= 4'h0;
    end else if (sck_q && !i_sck) begin
      o_si <= sh[0];
      sh   <= {~sh[0], sh[7:1]};
    end else if (!sck_q && i_sck) begin
      o_rx  <= {i_so, o_rx[7:1]};
      o_nrx <= o_nrx + 4'h1;
    end
  end
  // Pin clock only runs in bursts and stands high between them
  task automatic burst(input int n);
    repeat (n) begin
      repeat (3) @(posedge i_clk);
      o_xck <= 1'b0;
      repeat (3) @(posedge i_clk);
      o_xck <= 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ===== verif/ssx_core_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssx_defs.vh"
module ssx_core_tb_top;
  localparam logic [7:0] A_CT = `SSX_ADDR_CTRL;
  localparam logic [7:0] A_DT = `SSX_ADDR_DATA;
  localparam logic [7:0] A_ST = `SSX_ADDR_STATUS;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        ld = 1'b0;
  logic [7:0]  ptx = 8'h00;
  wire  [31:0] prdata;
  wire         pready, pslverr, sclk_out, sclk_oe, sout, irq, sin, xck;
  wire  [7:0]  prx;
  wire  [3:0]  nrx;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          irq_n = 0;
  int          k;
  integer      seed = 32'h26e301d5;
  logic [31:0] r;
  logic        e;
  logic [7:0]  b, c;
  // Pin level: the device drives it only with its own clock chosen
  wire sck = sclk_oe ? sclk_out : xck;
  initial forever #4 clk = ~clk;
  ssx_core u_dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_sclk_in(xck), .o_sclk_out(sclk_out), .o_sclk_oe(sclk_oe),
    .i_serial_in(sin), .o_serial_out(sout), .o_buffer_event_irq(irq));
  ssx_peer u_peer (.i_clk(clk), .i_sck(sck), .i_so(sout), .i_ld(ld),
    .i_tx(ptx), .o_si(sin), .o_xck(xck), .o_rx(prx), .o_nrx(nrx));
  // Watchdog and event count
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_n <= irq_n + 1;
    if (cyc == 8000) begin
      bad_count++;
      close_out();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Setup then access; data taken at the edge where pready is high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task automatic pload(input logic [7:0] v);
    @(posedge clk);
    ptx <= v;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
  endtask
  task automatic wait_bits;
    while (nrx != 4'h8) @(posedge clk);
  endtask
  task automatic wait_irq(input int d);
    while (irq_n < k + d) @(posedge clk);
  endtask
  // A stalled clock gives the peer no further edge
  task automatic parked;
    repeat (40) @(posedge clk);
    chk(nrx, 8);
    chk(sck, 1);
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdc(A_CT, `SSX_CTRL_RESET);
    rdc(A_ST, 32'h0);
    rdc(8'h0c, 32'h0);
    chk(e, 1);
    // Transmit, own clock: park, resume on write, stop mid-byte
    r = $random(seed);
    b = r[7:0];
    r = $random(seed);
    c = r[7:0];
    k = irq_n;
    apb(1'b1, A_CT, 32'h00);
    apb(1'b1, A_DT, b);
    pload(8'h00);
    apb(1'b1, A_CT, 32'h80);
    wait_irq(1);
    wait_bits;
    chk(prx, b);
    rdc(A_ST, 32'h8);
    parked;
    pload(8'h00);
    apb(1'b1, A_DT, c);
    wait_irq(2);
    apb(1'b1, A_CT, 32'h00);
    wait_bits;
    chk(prx, c);
    rdc(A_ST, 32'h0);
    // Receive, own clock: park until read, stop during next byte
    k = irq_n;
    apb(1'b1, A_CT, 32'h30);
    pload(b);
    apb(1'b1, A_CT, 32'hb0);
    wait_irq(1);
    parked;
    pload(c);
    rdc(A_DT, b);
    apb(1'b1, A_CT, 32'h30);
    wait_irq(2);
    rdc(A_DT, c);
    rdc(A_ST, 32'h0);
    // Both ways, own clock; parked after the read
    k = irq_n;
    apb(1'b1, A_CT, 32'h20);
    apb(1'b1, A_DT, c);
    pload(b);
    apb(1'b1, A_CT, 32'ha0);
    wait_irq(1);
    wait_bits;
    chk(prx, c);
    rdc(A_DT, b);
    parked;
    pload(c);
    apb(1'b1, A_DT, {24'h0, b});
    apb(1'b1, A_CT, 32'h20);
    wait_irq(2);
    wait_bits;
    chk(prx, b);
    rdc(A_DT, c);
    rdc(A_ST, 32'h0);
    apb(1'b1, A_CT, 32'h90);
    rdc(A_ST, 32'h0);
    // Pin clock: a byte out, then abort inside the dummy byte
    r = $random(seed);
    b = r[7:0];
    r = $random(seed);
    c = r[7:0];
    apb(1'b1, A_CT, 32'h07);
    apb(1'b1, A_DT, b);
    chk(sclk_oe, 0);
    pload(8'h00);
    apb(1'b1, A_CT, 32'h87);
    u_peer.burst(8);
    wait_bits;
    chk(prx, b);
    u_peer.burst(3);
    apb(1'b1, A_CT, 32'h47);
    rdc(A_ST, 32'h0);
    // Pin clock receive keeps going; abort drops the partial byte
    k = irq_n;
    apb(1'b1, A_CT, 32'h37);
    pload(c);
    apb(1'b1, A_CT, 32'hb7);
    u_peer.burst(8);
    wait_irq(1);
    rdc(A_DT, c);
    pload(b);
    u_peer.burst(8);
    wait_irq(2);
    rdc(A_DT, b);
    u_peer.burst(4);
    apb(1'b1, A_CT, 32'h77);
    rdc(A_ST, 32'h0);
    rdc(A_DT, b);
    close_out();
  end
endmodule
`default_nettype wire
